// file: src/tec_params.svh
// offsets, field positions, reset values and timing counts of the timer/event counter
`ifndef TEC_PARAMS_SVH
`define TEC_PARAMS_SVH

// register byte addresses on the apb slave
`define TEC_ADDR_W            8
`define TEC_OFS_COUNT         8'h00
`define TEC_OFS_CTRL          8'h04
`define TEC_OFS_IRQ           8'h08

// timer_control field positions
`define TEC_CTRL_PSC_LSB      0
`define TEC_CTRL_PSC_MSB      2
`define TEC_CTRL_EDGE_BIT     3
`define TEC_CTRL_RUN_BIT      4
`define TEC_CTRL_MODE_LOW_BIT 6
`define TEC_CTRL_MODE_HI_BIT  7

// interrupt control field positions
`define TEC_IRQ_EN_BIT        0
`define TEC_IRQ_FLAG_BIT      1

// reset values
`define TEC_COUNT_RST         8'h00
`define TEC_PRELOAD_RST       8'h00
`define TEC_CTRL_PSC_RST      3'h0
`define TEC_CTRL_MODE_RST     2'h0

// counter limits
`define TEC_FULL_COUNT        8'hff

// prescaler division ratios per select value
`define TEC_DIV_SEL0          8'h01
`define TEC_DIV_SEL1          8'h02
`define TEC_DIV_SEL2          8'h04
`define TEC_DIV_SEL3          8'h08
`define TEC_DIV_SEL4          8'h10
`define TEC_DIV_SEL5          8'h20
`define TEC_DIV_SEL6          8'h40
`define TEC_DIV_SEL7          8'h80

`endif

// file: src/tec_pkg.sv
// types shared by the timer/event counter
package tec_pkg;

    typedef enum logic [1:0] {
        TEC_MODE_OFF   = 2'b00,
        TEC_MODE_EVENT = 2'b01,
        TEC_MODE_TIMER = 2'b10,
        TEC_MODE_PULSE = 2'b11
    } tec_mode_e;

    typedef enum logic [1:0] {
        TEC_PW_IDLE  = 2'b00,
        TEC_PW_ARMED = 2'b01,
        TEC_PW_COUNT = 2'b10
    } tec_pw_e;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } tec_apb_req_s;

    typedef struct packed {
        logic [1:0] mode;
        logic       run;
        logic       edge_select;
        logic [2:0] prescale_sel;
    } tec_ctrl_s;

    typedef struct packed {
        logic [7:0]  count;
        logic [7:0]  preload;
        tec_ctrl_s   ctrl;
        logic        irq_en;
        logic        irq_flag;
        logic        pin_sync1;
        logic        pin_sync2;
        logic        pin_prev;
        logic [7:0]  presc_cnt;
        tec_pw_e     pw_state;
        logic        pw_pending;
        logic [31:0] prdata;
        logic        overflow;
        logic        wake;
    } tec_state_s;

endpackage

// file: src/tec_timer.sv
// 8-bit timer/event counter with preload, prescaler and apb register slave
//
// Behaviour
// - timer and pulse modes count prescaled clock; event mode counts pin transitions
// - control bits 2..0 pick the prescaler division ratio
// - prescaler select is ignored while counting pin events
// - counter adds exactly one per qualifying tick or pin transition
// - at full count: reload from preload, keep counting, raise request
// - count write while stopped loads counter and preload at once
// - count write while running loads preload only; counter takes it at overflow
// - preload has no meaningful reset value; software loads it first
// - mode high 1, low 0 selects interval timer
// - mode high 0, low 1 selects event counting
// - both mode bits one selects pulse-width measurement
// - control bit 4 runs or stops the counter
// - control bit 3 picks active pin polarity in event and pulse modes
// - interval mode counts once per prescaled clock period
// - event mode counts rising pin edges, or falling when edge select high
// - event counting goes on in power-down; overflow then wakes the device
// - interrupt output only when the enable bit is set
// - edge select low: count after falling edge, stop and clear run when high
// - edge select high: count after rising edge, stop and clear run when low
// - timer and event modes never clear run by hardware
// - after auto stop pin is ignored until software sets run again
// - pulse measurement starts on a transition, not on a level
// - every overflow sets the request flag, enabled or not
// - counting is held off while count is read or written
// - pin events in pulse mode act at the next timer tick
`timescale 1ns/1ns
`default_nettype none
`include "tec_params.svh"

module tec_timer
    import tec_pkg::*;
(
    input  wire logic         core_clk_i,
    input  wire logic         resetn_i,
    input  wire tec_apb_req_s apb_req_i,
    output logic [31:0]       prdata_o,
    output logic              pready_o,
    output logic              pslverr_o,
    input  wire logic         event_pin_i,
    input  wire logic         powerdown_i,
    output logic              timer_irq_o,
    output logic              overflow_o,
    output logic              wake_o
);

    tec_state_s st_reg;
    tec_state_s st_next;

    logic       rise;
    logic       fall;
    logic       tick;
    logic [7:0] ratio;
    logic       inc;
    logic       hw_stop;
    logic       start_edge;
    logic       level_active;
    logic       inhibit;
    logic       acc_wr;
    logic       setup_rd;
    logic       mapped;
    logic       hit_count;
    logic       hit_ctrl;
    logic       hit_irq;
    logic       flag_set;
    tec_mode_e  mode;

    // table lookup keeps the ratios in one place
    function automatic logic [7:0] presc_ratio(input logic [2:0] sel);
        logic [7:0] r;
        r = `TEC_DIV_SEL0;
        case (sel)
            3'h0: r = `TEC_DIV_SEL0;
            3'h1: r = `TEC_DIV_SEL1;
            3'h2: r = `TEC_DIV_SEL2;
            3'h3: r = `TEC_DIV_SEL3;
            3'h4: r = `TEC_DIV_SEL4;
            3'h5: r = `TEC_DIV_SEL5;
            3'h6: r = `TEC_DIV_SEL6;
            3'h7: r = `TEC_DIV_SEL7;
            default: r = `TEC_DIV_SEL0;
        endcase
        return r;
    endfunction

    always_comb
    begin
        st_next      = st_reg;
        st_next.overflow = 1'b0;
        st_next.wake     = 1'b0;
        inc          = 1'b0;
        hw_stop      = 1'b0;
        flag_set     = 1'b0;

        // synchroniser, first flop feeds only the second
        st_next.pin_sync1 = event_pin_i;
        st_next.pin_sync2 = st_reg.pin_sync1;
        st_next.pin_prev  = st_reg.pin_sync2;
        rise = st_reg.pin_sync2 & ~st_reg.pin_prev;
        fall = ~st_reg.pin_sync2 & st_reg.pin_prev;

        // free running prescaler; >= so a smaller ratio takes effect at once
        ratio = presc_ratio(st_reg.ctrl.prescale_sel);
        tick  = (st_reg.presc_cnt >= ratio - 8'h01);
        if (tick)
        begin
            st_next.presc_cnt = 8'h00;
        end
        else
        begin
            st_next.presc_cnt = st_reg.presc_cnt + 8'h01;
        end

        // apb decode
        hit_count = (apb_req_i.paddr == `TEC_OFS_COUNT);
        hit_ctrl  = (apb_req_i.paddr == `TEC_OFS_CTRL);
        hit_irq   = (apb_req_i.paddr == `TEC_OFS_IRQ);
        mapped    = hit_count | hit_ctrl | hit_irq;
        acc_wr    = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite & mapped;
        setup_rd  = apb_req_i.psel & ~apb_req_i.penable & ~apb_req_i.pwrite;
        // held over setup and access so the captured value is the one returned
        inhibit   = apb_req_i.psel & hit_count;

        mode = tec_mode_e'(st_reg.ctrl.mode);
        start_edge   = st_reg.ctrl.edge_select ? rise : fall;
        level_active = st_reg.ctrl.edge_select ? st_reg.pin_sync2 : ~st_reg.pin_sync2;

        case (mode)
            TEC_MODE_TIMER:
            begin
                inc = st_reg.ctrl.run & tick;
                st_next.pw_state   = TEC_PW_IDLE;
                st_next.pw_pending = 1'b0;
            end
            TEC_MODE_EVENT:
            begin
                // no tick term: prescaler has no say here
                inc = st_reg.ctrl.run & (st_reg.ctrl.edge_select ? fall : rise);
                st_next.pw_state   = TEC_PW_IDLE;
                st_next.pw_pending = 1'b0;
            end
            TEC_MODE_PULSE:
            begin
                case (st_reg.pw_state)
                    TEC_PW_IDLE:
                    begin
                        // arming here means only later transitions count
                        if (st_reg.ctrl.run)
                        begin
                            st_next.pw_state   = TEC_PW_ARMED;
                            st_next.pw_pending = 1'b0;
                        end
                    end
                    TEC_PW_ARMED:
                    begin
                        if (start_edge)
                        begin
                            st_next.pw_pending = 1'b1;
                        end
                        // edge acts at the next timer tick
                        if (tick & (st_reg.pw_pending | start_edge))
                        begin
                            st_next.pw_state   = TEC_PW_COUNT;
                            st_next.pw_pending = 1'b0;
                        end
                    end
                    TEC_PW_COUNT:
                    begin
                        if (tick)
                        begin
                            if (!level_active)
                            begin
                                hw_stop = 1'b1;
                                st_next.pw_state = TEC_PW_IDLE;
                            end
                            else
                            begin
                                inc = 1'b1;
                            end
                        end
                    end
                    default:
                    begin
                        st_next.pw_state   = TEC_PW_IDLE;
                        st_next.pw_pending = 1'b0;
                    end
                endcase
                if (!st_reg.ctrl.run)
                begin
                    st_next.pw_state   = TEC_PW_IDLE;
                    st_next.pw_pending = 1'b0;
                end
            end
            default:
            begin
                inc = 1'b0;
                st_next.pw_state   = TEC_PW_IDLE;
                st_next.pw_pending = 1'b0;
            end
        endcase

        // hardware only clears run in pulse mode
        if (hw_stop)
        begin
            st_next.ctrl.run = 1'b0;
        end

        if (inc & ~inhibit)
        begin
            if (st_reg.count == `TEC_FULL_COUNT)
            begin
                st_next.count    = st_reg.preload;
                st_next.overflow = 1'b1;
                st_next.wake     = powerdown_i;
                flag_set         = 1'b1;
            end
            else
            begin
                st_next.count = st_reg.count + 8'h01;
            end
        end
        if (flag_set)
        begin
            st_next.irq_flag = 1'b1;
        end

        // register writes; a same-cycle hardware set beats a software clear
        if (acc_wr)
        begin
            if (hit_count)
            begin
                st_next.preload = apb_req_i.pwdata[7:0];
                if (!st_reg.ctrl.run)
                begin
                    st_next.count = apb_req_i.pwdata[7:0];
                end
            end
            if (hit_ctrl)
            begin
                st_next.ctrl.prescale_sel = apb_req_i.pwdata[`TEC_CTRL_PSC_MSB:`TEC_CTRL_PSC_LSB];
                st_next.ctrl.edge_select  = apb_req_i.pwdata[`TEC_CTRL_EDGE_BIT];
                st_next.ctrl.run          = apb_req_i.pwdata[`TEC_CTRL_RUN_BIT];
                st_next.ctrl.mode = {apb_req_i.pwdata[`TEC_CTRL_MODE_HI_BIT],
                                     apb_req_i.pwdata[`TEC_CTRL_MODE_LOW_BIT]};
            end
            if (hit_irq)
            begin
                st_next.irq_en   = apb_req_i.pwdata[`TEC_IRQ_EN_BIT];
                st_next.irq_flag = apb_req_i.pwdata[`TEC_IRQ_FLAG_BIT] | flag_set;
            end
        end

        // read data captured in setup, presented in access
        if (setup_rd)
        begin
            st_next.prdata = 32'h0000_0000;
            if (hit_count)
            begin
                st_next.prdata[7:0] = st_reg.count;
            end
            if (hit_ctrl)
            begin
                st_next.prdata[`TEC_CTRL_PSC_MSB:`TEC_CTRL_PSC_LSB] = st_reg.ctrl.prescale_sel;
                st_next.prdata[`TEC_CTRL_EDGE_BIT]     = st_reg.ctrl.edge_select;
                st_next.prdata[`TEC_CTRL_RUN_BIT]      = st_reg.ctrl.run;
                st_next.prdata[`TEC_CTRL_MODE_LOW_BIT] = st_reg.ctrl.mode[0];
                st_next.prdata[`TEC_CTRL_MODE_HI_BIT]  = st_reg.ctrl.mode[1];
            end
            if (hit_irq)
            begin
                st_next.prdata[`TEC_IRQ_EN_BIT]   = st_reg.irq_en;
                st_next.prdata[`TEC_IRQ_FLAG_BIT] = st_reg.irq_flag;
            end
        end
    end

    // preload reset is only a fixed filler; software must load it first
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_reg                   <= '0;
            st_reg.count             <= `TEC_COUNT_RST;
            st_reg.preload           <= `TEC_PRELOAD_RST;
            st_reg.ctrl.prescale_sel <= `TEC_CTRL_PSC_RST;
            st_reg.ctrl.mode         <= `TEC_CTRL_MODE_RST;
            st_reg.pw_state          <= TEC_PW_IDLE;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign prdata_o    = st_reg.prdata;
    assign pready_o    = 1'b1;
    assign pslverr_o   = apb_req_i.psel & apb_req_i.penable & ~mapped;
    assign timer_irq_o = st_reg.irq_flag & st_reg.irq_en;
    assign overflow_o  = st_reg.overflow;
    assign wake_o      = st_reg.wake;

endmodule
`default_nettype wire

// file: dv/tec_timer_props.sv
// assertion checker for the timer/event counter ports
`timescale 1ns/1ns
`default_nettype none
`include "tec_params.svh"
module tec_timer_props
    import tec_pkg::*;
(
    input wire logic         core_clk_i,
    input wire logic         resetn_i,
    input wire tec_apb_req_s apb_req_i,
    input wire logic [31:0]  prdata_o,
    input wire logic         pready_o,
    input wire logic         pslverr_o,
    input wire logic         powerdown_i,
    input wire logic         timer_irq_o,
    input wire logic         overflow_o,
    input wire logic         wake_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);
    logic acc;
    logic rd;
    logic unm;
    logic irq_wr;
    assign acc    = apb_req_i.psel && apb_req_i.penable;
    assign rd     = acc && !apb_req_i.pwrite;
    assign unm    = !(apb_req_i.paddr inside {`TEC_OFS_COUNT, `TEC_OFS_CTRL, `TEC_OFS_IRQ});
    assign irq_wr = acc && apb_req_i.pwrite && apb_req_i.paddr == `TEC_OFS_IRQ;
    chk_ready_high: assert property (pready_o) else $error("pready low");
    chk_err_unmapped: assert property (pslverr_o == (acc && unm)) else $error("pslverr wrong");
    chk_read_upper: assert property (rd |-> prdata_o[31:8] == 24'h0) else $error("read upper bits set");
    chk_read_unmapped: assert property (rd && unm |-> prdata_o == 32'h0) else $error("unmapped read");
    chk_ctrl_spare: assert property (rd && apb_req_i.paddr == `TEC_OFS_CTRL |-> !prdata_o[5])
        else $error("control bit 5 set");
    chk_wake_pd: assert property (overflow_o |-> wake_o == $past(powerdown_i))
        else $error("wake mismatch");
    chk_wake_ovf: assert property (wake_o |-> overflow_o) else $error("wake without overflow");
    chk_irq_rise: assert property ($rose(timer_irq_o) |-> overflow_o || $past(irq_wr))
        else $error("irq rose without cause");
    chk_irq_fall: assert property ($fell(timer_irq_o) |-> $past(irq_wr))
        else $error("irq fell without write");
    cover property (overflow_o && timer_irq_o);
    cover property (wake_o);
    cover property (pslverr_o);
endmodule
bind tec_timer tec_timer_props u_tec_timer_props (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .apb_req_i(apb_req_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .powerdown_i(powerdown_i), .timer_irq_o(timer_irq_o), .overflow_o(overflow_o), .wake_o(wake_o));
`default_nettype wire

// file: dv/tec_pin_src.sv
// behavioural source of events and pulses on the timer pin
`timescale 1ns/1ns
`default_nettype none
module tec_pin_src
(
    input  wire logic clk_i,
    output logic      pin_o
);
    // pin is a pure input of the block, idling low
    initial
    begin
        pin_o = 1'b0;
    end
    task automatic setl(input logic v);
        @(posedge clk_i);
        pin_o <= v;
    endtask
    // gap sets how slow the source is
    task automatic toggle(input int n, input int gap);
        repeat (n)
        begin
            repeat (gap) @(posedge clk_i);
            pin_o <= ~pin_o;
        end
    endtask
endmodule
`default_nettype wire

// file: dv/tb_tec_timer.sv
// self-checking bench of the timer/event counter
`timescale 1ns/1ns
`default_nettype none
`include "tec_params.svh"
module tb_tec_timer
    import tec_pkg::*;
;
    localparam logic [7:0] CNT = `TEC_OFS_COUNT;
    localparam logic [7:0] CTL = `TEC_OFS_CTRL;
    localparam logic [7:0] IRQ = `TEC_OFS_IRQ;
    logic         core_clk_i = 1'b0;
    logic         resetn_i = 1'b0;
    tec_apb_req_s req = '0;
    logic         pin;
    logic         pd = 1'b0;
    logic [31:0]  prdata;
    logic         pready, err, slverr, irq, ovf, wake;
    int           failures = 0, check_count = 0, cyc = 0, ovf_n = 0, wake_n = 0, last_ovf = 0;
    always #4 core_clk_i = ~core_clk_i;
    tec_timer u_tec_timer (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .apb_req_i(req), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(slverr), .event_pin_i(pin), .powerdown_i(pd), .timer_irq_o(irq),
        .overflow_o(ovf), .wake_o(wake));
    tec_pin_src u_tec_pin_src (.clk_i(core_clk_i), .pin_o(pin));
    always @(posedge core_clk_i)
    begin
        cyc++;
        if (ovf === 1'b1)
        begin
            ovf_n++;
            last_ovf = cyc;
        end
        if (wake === 1'b1)
            wake_n++;
        if (cyc == 60000)
        begin
            failures++;
            summarize();
        end
    end
    function automatic logic [7:0] ctl(int m, int r, int e, int s);
        return 8'(m << 6 | r << 4 | e << 3 | s);
    endfunction
    task automatic check_eq(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_in(input string what, input int lo, input int hi, input logic [31:0] got);
        check_eq(what, 32'h1, {31'h0, got >= lo && got <= hi});
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] rd);
        @(posedge core_clk_i);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= w;
        req.paddr   <= a;
        req.pwdata  <= {24'h0, d};
        @(posedge core_clk_i);
        req.penable <= 1'b1;
        do
            @(posedge core_clk_i);
        while (pready !== 1'b1);
        rd  = prdata;
        err = slverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] x;
        apb(1'b1, a, d, x);
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        apb(1'b0, a, 8'h00, x);
        check_eq(what, exp, x);
    endtask
    // overflow pulses are counted by the monitor, so a late wake-up loses none
    task automatic wait_ovf(output int c);
        int s;
        s = ovf_n;
        while (ovf_n == s)
            @(posedge core_clk_i);
        c = last_ovf;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        int sel, p, p2, t0, t1, e, n, c, ov, o0, w0, w;
        logic [31:0] x;
        void'($urandom(54));
        repeat (2) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        rdchk("ctrl rst", CTL, 32'h0);
        rdchk("irq rst", IRQ, 32'h0);
        rdchk("unmapped", 8'h0c, 32'h0);
        check_eq("slverr", 32'h1, {31'h0, err});
        wr(CNT, 8'h5a);
        rdchk("load stopped", CNT, 32'h5a);
        for (sel = 0; sel < 8; sel++)
        begin
            p  = $urandom_range(254, 240);
            p2 = $urandom_range(254, 240);
            wr(CTL, ctl(2, 0, 0, sel));
            wr(CNT, 8'(p));
            wr(CTL, ctl(2, 1, 0, sel));
            wait_ovf(t0);
            wait_ovf(t1);
            check_eq("period", (256 - p) << sel, t1 - t0);
            wr(CNT, 8'(p2));
            wait_ovf(t0);
            wait_ovf(t1);
            check_eq("reload", (256 - p2) << sel, t1 - t0);
            rdchk("run kept", CTL, ctl(2, 1, 0, sel));
        end
        // both phases of a count read hold the counter; only the idle edge between reads counts
        wr(CTL, ctl(2, 0, 0, 0));
        wr(CNT, 8'h10);
        wr(CTL, ctl(2, 1, 0, 0));
        apb(1'b0, CNT, 8'h00, x);
        rdchk("read hold", CNT, x + 32'h1);
        wr(CTL, ctl(2, 0, 0, 0));
        rdchk("flag", IRQ, 32'h2);
        check_eq("irq masked", 32'h0, {31'h0, irq});
        wr(IRQ, 8'h03);
        @(posedge core_clk_i);
        check_eq("irq on", 32'h1, {31'h0, irq});
        wr(IRQ, 8'h01);
        @(posedge core_clk_i);
        check_eq("irq clr", 32'h0, {31'h0, irq});
        pd <= 1'b1;
        for (e = 0; e < 2; e++)
        begin
            sel = $urandom_range(7, 0);
            n   = $urandom_range(9, 4);
            c   = 254;
            ov  = 0;
            wr(CTL, ctl(1, 0, e, sel));
            wr(CNT, 8'hfe);
            wr(CTL, ctl(1, 1, e, sel));
            o0 = ovf_n;
            w0 = wake_n;
            u_tec_pin_src.toggle(n, 4);
            repeat (8) @(posedge core_clk_i);
            for (int i = 0; i < (e ? n / 2 : (n + 1) / 2); i++)
            begin
                ov += (c == 255);
                c  = (c == 255) ? 254 : c + 1;
            end
            rdchk("events", CNT, c);
            check_eq("ovf n", ov, ovf_n - o0);
            check_eq("wake n", ov, wake_n - w0);
            rdchk("run held", CTL, ctl(1, 1, e, sel));
            wr(CTL, ctl(1, 0, e, sel));
            if (n % 2)
                u_tec_pin_src.toggle(1, 1);
        end
        check_eq("irq event", 32'h1, {31'h0, irq});
        pd <= 1'b0;
        for (e = 0; e < 2; e++)
        begin
            w = $urandom_range(40, 5);
            u_tec_pin_src.setl(e[0]);
            wr(CTL, ctl(3, 0, e, 0));
            wr(CNT, 8'h00);
            wr(CTL, ctl(3, 1, e, 0));
            repeat (20) @(posedge core_clk_i);
            rdchk("level", CNT, 32'h0);
            u_tec_pin_src.setl(!e[0]);
            repeat (8) @(posedge core_clk_i);
            u_tec_pin_src.setl(e[0]);
            repeat (w - 1) @(posedge core_clk_i);
            u_tec_pin_src.setl(!e[0]);
            repeat (12) @(posedge core_clk_i);
            apb(1'b0, CNT, 8'h00, x);
            check_in("width", w - 2, w + 1, x);
            rdchk("auto stop", CTL, ctl(3, 0, e, 0));
            u_tec_pin_src.toggle(2, 4);
            repeat (8) @(posedge core_clk_i);
            rdchk("one shot", CNT, x);
        end
        wr(CNT, 8'h33);
        wr(CTL, ctl(0, 1, 0, 0));
        u_tec_pin_src.toggle(4, 4);
        rdchk("mode off", CNT, 32'h33);
        summarize();
    end
endmodule
`default_nettype wire
